// ---- inc/spsc_pkg.sv ----
// Purpose: constants and types of the standby pin-state controller
// Assumes: APB register map, one word per register
// Notes:   all offsets are byte addresses
package spsc_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] DATA_OFF    = 8'h04;
  localparam logic [7:0] DIR_OFF     = 8'h08;
  localparam logic [7:0] PULL_OFF    = 8'h0C;
  localparam logic [7:0] PIN_OFF     = 8'h10;
  localparam logic [7:0] OSC_OFF     = 8'h14;
  localparam logic [7:0] XINT_OFF    = 8'h18;
  localparam logic [7:0] IRQ_ST_OFF  = 8'h1C;
  localparam logic [7:0] IRQ_MSK_OFF = 8'h20;

  // ------------------------------------------------------------------
  // control register fields and reset values
  // ------------------------------------------------------------------
  localparam int          CTRL_FLOAT_BIT  = 0;
  localparam int          CTRL_RSTPIN_BIT = 1;
  localparam int          CTRL_CMPIRQ_BIT = 2;
  localparam int          CTRL_I2CWK_BIT  = 3;
  localparam logic [3:0]  CTRL_RESET      = 4'h2;
  localparam int          CTRL_W          = 4;

  // ------------------------------------------------------------------
  // interrupt status bits
  // ------------------------------------------------------------------
  localparam int          IRQ_ENTER_BIT = 0;
  localparam int          IRQ_LEAVE_BIT = 1;
  localparam int          IRQ_WAKE_BIT  = 2;
  localparam int          IRQ_W         = 3;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;

  // ------------------------------------------------------------------
  // operating modes from the power manager, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    SPSC_NORMAL = 4'b0001,
    SPSC_SLEEP  = 4'b0010,
    SPSC_STOP   = 4'b0100,
    SPSC_WATCH  = 4'b1000
  } spsc_mode_t;

  // ------------------------------------------------------------------
  // pad drive bundle, one per pin
  // ------------------------------------------------------------------
  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } spsc_pad_t;

endpackage : spsc_pkg

// ---- rtl/spsc_ctrl.sv ----
// Purpose: port pin state control across normal, sleep, stop and watch modes
// Assumes: mode comes from the power manager on clk; pins enter asynchronously
// Notes:   pin classes are fixed per pin by mask parameters
//
// What this block does
// - normal and sleep modes leave pins as port or peripheral I/O, ungated except oscillator pins.
// - in stop/watch, float select 0 holds outputs, 1 floats them.
// - blocked pins have their direct input gate disabled toward internal logic.
// - float select 1 in stop/watch floats all pins, inputs held low.
// - in reset digital pins float with input enabled, analog pins blocked.
// - marked pins keep their pull-up setting while floated in standby.
// - interrupt pins still feed the interrupt detector when its request is enabled.
// - comparator inputs still route analog signal when comparator interrupt enabled.
// - comparator outputs keep driving live output in standby with float select 0.
// - I2C pins may wake the controller from standby when wake-up enabled.
// - shared reset pin stays a reset input in every mode when selected.
// - oscillator pins float in every mode once selected, port table only as GPIO.
`timescale 1ns/10ps
module spsc_ctrl #(
  parameter int               NPIN      = 8,
  parameter logic [NPIN-1:0]  XINT_MASK = 8'h0F,
  parameter logic [NPIN-1:0]  CMPI_MASK = 8'h30,
  parameter logic [NPIN-1:0]  CMPO_MASK = 8'h40,
  parameter logic [NPIN-1:0]  ANA_MASK  = 8'h70,
  parameter logic [NPIN-1:0]  PULL_MASK = 8'h3F,
  parameter logic [NPIN-1:0]  I2C_MASK  = 8'hC0,
  parameter logic [NPIN-1:0]  OSC_MASK  = 8'h03
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  output logic                               irq,
  input  wire spsc_pkg::spsc_mode_t          mode,
  input  wire logic [NPIN-1:0]               pin_in,
  output spsc_pkg::spsc_pad_t [NPIN-1:0]     pad_o,
  output logic [NPIN-1:0]                    pin_in_en,
  input  wire logic [NPIN-1:0]               periph_sel,
  input  wire logic [NPIN-1:0]               periph_out,
  input  wire logic [NPIN-1:0]               periph_oe,
  input  wire logic [NPIN-1:0]               cmp_out,
  output logic [NPIN-1:0]                    port_in,
  output logic [NPIN-1:0]                    xint_level,
  output logic [NPIN-1:0]                    cmp_route_en,
  output logic [NPIN-1:0]                    i2c_wake_level,
  input  wire logic                          rst_pin_in,
  output logic                               ext_reset_req
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [spsc_pkg::CTRL_W-1:0] ctrl_reg;
  logic [NPIN-1:0]             data_reg;
  logic [NPIN-1:0]             dir_reg;
  logic [NPIN-1:0]             pull_reg;
  logic [NPIN-1:0]             osc_reg;
  logic [NPIN-1:0]             xint_en_reg;
  logic [spsc_pkg::IRQ_W-1:0]  irq_st_reg;
  logic [spsc_pkg::IRQ_W-1:0]  irq_msk_reg;
  logic [NPIN-1:0]             pad_out_reg;
  logic [NPIN-1:0]             pad_oe_reg;
  logic [NPIN-1:0]             pad_pu_reg;
  logic [NPIN-1:0]             in_en_reg;
  logic [NPIN-1:0]             port_in_reg;
  logic [NPIN-1:0]             xint_reg;
  logic [NPIN-1:0]             cmp_route_reg;
  logic [NPIN-1:0]             i2c_reg;
  logic [NPIN-1:0]             pin_s1_reg;
  logic [NPIN-1:0]             pin_s2_reg;
  logic                        rst_s1_reg;
  logic                        rst_s2_reg;
  logic                        ext_rst_reg;
  logic                        standby_reg;
  logic [31:0]                 prdata_reg;
  logic                        standby;
  logic                        float_sel;
  logic                        wr_en;
  logic                        rd_setup;
  logic                        addr_ok;
  logic                        wake_ev;
  logic [NPIN-1:0]             run_out;
  logic [NPIN-1:0]             run_oe;
  logic [spsc_pkg::IRQ_W-1:0]  irq_set;
  logic [spsc_pkg::IRQ_W-1:0]  irq_clr;

  // ------------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------------
  always_comb begin
    unique case (mode)
      spsc_pkg::SPSC_NORMAL: standby = 1'b0;
      spsc_pkg::SPSC_SLEEP:  standby = 1'b0;
      spsc_pkg::SPSC_STOP:   standby = 1'b1;
      spsc_pkg::SPSC_WATCH:  standby = 1'b1;
      // a broken mode code is treated as running so pins stay usable
      default:               standby = 1'b0;
    endcase
  end

  assign float_sel = ctrl_reg[spsc_pkg::CTRL_FLOAT_BIT];

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      rst_s1_reg <= rst_pin_in;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // ------------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------------
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr  = psel & penable & ~addr_ok;
  assign prdata   = prdata_reg;

  always_comb begin
    unique case (paddr)
      spsc_pkg::CTRL_OFF, spsc_pkg::DATA_OFF, spsc_pkg::DIR_OFF,
      spsc_pkg::PULL_OFF, spsc_pkg::PIN_OFF, spsc_pkg::OSC_OFF,
      spsc_pkg::XINT_OFF, spsc_pkg::IRQ_ST_OFF,
      spsc_pkg::IRQ_MSK_OFF: addr_ok = 1'b1;
      default:               addr_ok = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= 32'h0000_0000;
      unique case (paddr)
        spsc_pkg::CTRL_OFF:    prdata_reg[spsc_pkg::CTRL_W-1:0] <= ctrl_reg;
        spsc_pkg::DATA_OFF:    prdata_reg[NPIN-1:0] <= data_reg;
        spsc_pkg::DIR_OFF:     prdata_reg[NPIN-1:0] <= dir_reg;
        spsc_pkg::PULL_OFF:    prdata_reg[NPIN-1:0] <= pull_reg;
        spsc_pkg::PIN_OFF:     prdata_reg[NPIN-1:0] <= port_in_reg;
        spsc_pkg::OSC_OFF:     prdata_reg[NPIN-1:0] <= osc_reg;
        spsc_pkg::XINT_OFF:    prdata_reg[NPIN-1:0] <= xint_en_reg;
        spsc_pkg::IRQ_ST_OFF:  prdata_reg[spsc_pkg::IRQ_W-1:0] <= irq_st_reg;
        spsc_pkg::IRQ_MSK_OFF: prdata_reg[spsc_pkg::IRQ_W-1:0] <= irq_msk_reg;
        default:               prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg    <= spsc_pkg::CTRL_RESET;
      data_reg    <= '0;
      dir_reg     <= '0;
      pull_reg    <= '0;
      osc_reg     <= '0;
      xint_en_reg <= '0;
      irq_msk_reg <= spsc_pkg::IRQ_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        spsc_pkg::CTRL_OFF:    ctrl_reg    <= pwdata[spsc_pkg::CTRL_W-1:0];
        spsc_pkg::DATA_OFF:    data_reg    <= pwdata[NPIN-1:0];
        spsc_pkg::DIR_OFF:     dir_reg     <= pwdata[NPIN-1:0];
        spsc_pkg::PULL_OFF:    pull_reg    <= pwdata[NPIN-1:0];
        spsc_pkg::OSC_OFF:     osc_reg     <= pwdata[NPIN-1:0] & OSC_MASK;
        spsc_pkg::XINT_OFF:    xint_en_reg <= pwdata[NPIN-1:0] & XINT_MASK;
        spsc_pkg::IRQ_MSK_OFF: irq_msk_reg <= pwdata[spsc_pkg::IRQ_W-1:0];
        default:               ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // pad drive
  // ------------------------------------------------------------------
  assign run_out = (periph_sel & periph_out) | (~periph_sel & data_reg);
  assign run_oe  = ((periph_sel & periph_oe) | (~periph_sel & dir_reg)) & ~osc_reg;

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
      // reset floats every pin
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pad_out_reg[i] <= 1'b0;
          pad_oe_reg[i]  <= 1'b0;
        end else if (!standby) begin
          pad_out_reg[i] <= run_out[i];
          pad_oe_reg[i]  <= run_oe[i];
        end else if (float_sel || osc_reg[i]) begin
          pad_oe_reg[i]  <= 1'b0;
        end else if (CMPO_MASK[i] && periph_sel[i]) begin
          pad_out_reg[i] <= cmp_out[i];
        end
      end

      // pull-up drops while driving low; unmarked pins lose it when floated
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pad_pu_reg[i] <= 1'b0;
        end else if (standby && float_sel) begin
          pad_pu_reg[i] <= pull_reg[i] & PULL_MASK[i] & ~osc_reg[i];
        end else begin
          pad_pu_reg[i] <= pull_reg[i] & ~osc_reg[i]
                           & ~(pad_oe_reg[i] & ~pad_out_reg[i]);
        end
      end

      assign pad_o[i].out = pad_out_reg[i];
      assign pad_o[i].oe  = pad_oe_reg[i];
      assign pad_o[i].pu  = pad_pu_reg[i];
    end
  endgenerate

  // ------------------------------------------------------------------
  // input gating and wake paths
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      in_en_reg     <= ~ANA_MASK;
      port_in_reg   <= '0;
      xint_reg      <= '0;
      cmp_route_reg <= '0;
      i2c_reg       <= '0;
    end else begin
      in_en_reg     <= standby ? '0 : ~osc_reg;
      port_in_reg   <= standby ? '0 : pin_s2_reg;
      xint_reg      <= pin_s2_reg & XINT_MASK & (standby ? xint_en_reg : XINT_MASK);
      cmp_route_reg <= CMPI_MASK & {NPIN{~standby | ctrl_reg[spsc_pkg::CTRL_CMPIRQ_BIT]}};
      i2c_reg       <= pin_s2_reg & I2C_MASK
                       & {NPIN{~standby | ctrl_reg[spsc_pkg::CTRL_I2CWK_BIT]}};
    end
  end

  assign pin_in_en      = in_en_reg;
  assign port_in        = port_in_reg;
  assign xint_level     = xint_reg;
  assign cmp_route_en   = cmp_route_reg;
  assign i2c_wake_level = i2c_reg;

  // ------------------------------------------------------------------
  // shared reset pin, active in every mode
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_rst_reg <= 1'b0;
    end else begin
      ext_rst_reg <= ctrl_reg[spsc_pkg::CTRL_RSTPIN_BIT] & ~rst_s2_reg;
    end
  end
  assign ext_reset_req = ext_rst_reg;

  // ------------------------------------------------------------------
  // interrupts: enter, leave and wake events, write one to clear
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      standby_reg <= 1'b0;
    end else begin
      standby_reg <= standby;
    end
  end

  assign wake_ev = standby_reg & (|(xint_reg & ~(pin_s2_reg & xint_en_reg)) | (|i2c_reg));
  assign irq_set = {wake_ev, standby_reg & ~standby, standby & ~standby_reg};
  assign irq_clr = (wr_en && paddr == spsc_pkg::IRQ_ST_OFF)
                   ? pwdata[spsc_pkg::IRQ_W-1:0] : '0;

  // a set in the same cycle as its clear wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_st_reg <= spsc_pkg::IRQ_RESET;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_st_reg & irq_msk_reg);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  run_drive_a: assert property (!standby |=> pad_oe_reg == $past(run_oe))
    else $error("pin direction not following port setting");
  hold_state_a: assert property ((standby && standby_reg && !float_sel) |=>
      (pad_oe_reg & ~$past(osc_reg)) == $past(pad_oe_reg & ~osc_reg))
    else $error("held pin drive changed in standby");
  gate_low_a: assert property (standby |=> port_in == '0)
    else $error("blocked input reached internal logic");
  float_all_a: assert property ((standby && float_sel) [*2] |=> pad_oe_reg == '0)
    else $error("pin driven while floated");
  pull_keep_a: assert property ((standby && float_sel) |=>
      (pad_pu_reg & PULL_MASK) == $past(pull_reg & PULL_MASK & ~osc_reg))
    else $error("pull-up lost on floated pin");
  xint_pass_a: assert property (standby |=>
      xint_level == $past(pin_s2_reg & xint_en_reg))
    else $error("interrupt pin level not passed in standby");
  cmp_route_a: assert property ((standby && ctrl_reg[spsc_pkg::CTRL_CMPIRQ_BIT]) |=>
      cmp_route_en == CMPI_MASK)
    else $error("comparator input not routed");
  cmp_live_a: assert property ((standby && !float_sel) |=>
      (pad_out_reg & CMPO_MASK & $past(periph_sel))
      == ($past(cmp_out) & CMPO_MASK & $past(periph_sel)))
    else $error("comparator output frozen");
  i2c_wake_a: assert property ((standby && ctrl_reg[spsc_pkg::CTRL_I2CWK_BIT]) |=>
      i2c_wake_level == $past(pin_s2_reg & I2C_MASK))
    else $error("bus wake path blocked");
  rst_pin_a: assert property ((ctrl_reg[spsc_pkg::CTRL_RSTPIN_BIT] && !rst_s2_reg)
      |=> ext_reset_req)
    else $error("reset pin ignored");
  osc_float_a: assert property (1'b1 |=> (pad_oe_reg & $past(osc_reg)) == '0)
    else $error("oscillator pin driven");
  set_wins_a: assert property ((irq_set[spsc_pkg::IRQ_ENTER_BIT])
      |=> irq_st_reg[spsc_pkg::IRQ_ENTER_BIT])
    else $error("event lost against clear");

  stop_float_c:  cover property (mode == spsc_pkg::SPSC_STOP && float_sel ##2 pad_oe_reg == '0);
  watch_hold_c:  cover property (mode == spsc_pkg::SPSC_WATCH && !float_sel && pad_oe_reg != '0);
  wake_irq_c:    cover property (irq_set[spsc_pkg::IRQ_WAKE_BIT] ##1 irq);
  leave_c:       cover property (standby_reg && !standby);

endmodule : spsc_ctrl

// ---- tb/spsc_board.sv ----
// Purpose: board circuitry model at the port pins
// Assumes: one resolved level per pin, board drive gated by drv_en
// Notes:   an undriven pin settles to the pull-up if on, else the board pull-down
`timescale 1ns/10ps
module spsc_board #(
  parameter int NPIN = 8
) (
  input  wire spsc_pkg::spsc_pad_t [NPIN-1:0] pad_o,
  input  wire logic [NPIN-1:0]               drv_en,
  input  wire logic [NPIN-1:0]               drv_val,
  output logic [NPIN-1:0]                    pin_lvl
);
  // ------------------------------------------------------------------
  // pin resolution
  // ------------------------------------------------------------------
  // never left open: an open input would leak, so the board pulls it down
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_o[i].oe)
        pin_lvl[i] = pad_o[i].out;
      else if (drv_en[i])
        pin_lvl[i] = drv_val[i];
      else
        pin_lvl[i] = pad_o[i].pu;
    end
  end
endmodule : spsc_board

// ---- tb/spsc_ctrl_tb.sv ----
// Purpose: self-checking bench of the standby pin-state controller
// Assumes: default pin-class masks of the design
// Notes:   expected values queue up; one monitor compares them
`timescale 1ns/10ps
module spsc_ctrl_tb;
  typedef struct packed {
    logic [3:0]  sel;
    logic [32:0] val;
  } spsc_note_t;
  logic                        clk = 1'b0;
  logic                        resetn = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [7:0]                  paddr = 8'h00;
  logic [31:0]                 pwdata = 32'h0;
  logic                        pready;
  logic [31:0]                 prdata;
  logic                        pslverr;
  logic                        irq;
  spsc_pkg::spsc_mode_t        mode = spsc_pkg::SPSC_NORMAL;
  logic [7:0]                  pin_in;
  spsc_pkg::spsc_pad_t [7:0]   pad_o;
  logic [7:0]                  pin_in_en, port_in, xint_level, cmp_route_en, i2c_wake_level;
  logic [7:0]                  periph_sel = 8'h00;
  logic [7:0]                  periph_out = 8'h00;
  logic [7:0]                  periph_oe = 8'h00;
  logic [7:0]                  cmp_out = 8'h00;
  logic [7:0]                  drv_en = 8'h00;
  logic [7:0]                  drv_val = 8'h00;
  logic                        rst_pin_in = 1'b1;
  logic                        ext_reset_req;
  logic [7:0]                  oe_v, out_v, pu_v;
  logic                        chk_go = 1'b0;
  logic [3:0]                  chk_sel = 4'h0;
  spsc_note_t                  exp_q[$];
  spsc_note_t                  note_v;
  int                          bad_count = 0;
  int                          checks_done = 0;

  always #10 clk = ~clk;

  spsc_ctrl spsc_ctrl_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq), .mode(mode), .pin_in(pin_in), .pad_o(pad_o),
    .pin_in_en(pin_in_en), .periph_sel(periph_sel), .periph_out(periph_out),
    .periph_oe(periph_oe), .cmp_out(cmp_out), .port_in(port_in), .xint_level(xint_level),
    .cmp_route_en(cmp_route_en), .i2c_wake_level(i2c_wake_level),
    .rst_pin_in(rst_pin_in), .ext_reset_req(ext_reset_req));
  spsc_board spsc_board_inst (.pad_o(pad_o), .drv_en(drv_en), .drv_val(drv_val),
    .pin_lvl(pin_in));

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      oe_v[i] = pad_o[i].oe;
      out_v[i] = pad_o[i].out;
      pu_v[i] = pad_o[i].pu;
    end
  end

  // ------------------------------------------------------------------
  // comparison and verdict
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [32:0] seen_v, input logic [32:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen_v, exp_v);
    end
  endtask : check

  function automatic logic [32:0] seen(input logic [3:0] s);
    case (s)
      4'h1: seen = {25'h0, oe_v};
      4'h2: seen = {25'h0, out_v};
      4'h3: seen = {25'h0, pu_v};
      4'h4: seen = {25'h0, pin_in_en};
      4'h5: seen = {25'h0, port_in};
      4'h6: seen = {25'h0, xint_level};
      4'h7: seen = {25'h0, cmp_route_en};
      4'h8: seen = {25'h0, i2c_wake_level};
      4'h9: seen = {32'h0, ext_reset_req};
      default: seen = {32'h0, irq};
    endcase
  endfunction : seen

  // the oldest note belongs to whichever result shows up first
  always @(posedge clk) begin
    if ((psel && penable && pready && !pwrite) || chk_go) begin
      if (exp_q.size() == 0) begin
        check(33'h0, 33'h1);
      end else begin
        note_v = exp_q.pop_front();
        check(chk_go ? seen(chk_sel) : {pslverr, prdata}, note_v.val);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  // ------------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back({4'h0, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic chk(input logic [3:0] s, input logic [32:0] e);
    exp_q.push_back({s, e});
    chk_sel <= s;
    chk_go <= 1'b1;
    @(posedge clk);
    chk_go <= 1'b0;
    @(posedge clk);
  endtask : chk

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    logic [7:0] d, e, cm;
    void'($urandom(32'h69c85d18));
    d = 8'($urandom());
    e = 8'($urandom());
    repeat (4) @(posedge clk);
    chk(4'h4, 33'h8F);
    chk(4'h1, 33'h0);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(spsc_pkg::CTRL_OFF, 33'h2);
    rd(spsc_pkg::IRQ_ST_OFF, 33'h0);
    rd(8'h3C, {1'b1, 32'h0});
    periph_sel <= 8'h40;
    periph_out <= 8'h40;
    periph_oe <= 8'h40;
    cmp_out <= 8'($urandom());
    apb(1'b1, spsc_pkg::DIR_OFF, 32'hFF);
    apb(1'b1, spsc_pkg::DATA_OFF, {24'h0, d});
    repeat (3) @(posedge clk);
    chk(4'h1, 33'hFF);
    chk(4'h2, {25'h0, (d & 8'hBF) | 8'h40});
    mode <= spsc_pkg::SPSC_SLEEP;
    drv_val <= e;
    drv_en <= 8'hFF;
    apb(1'b1, spsc_pkg::DIR_OFF, 32'h0);
    repeat (4) @(posedge clk);
    chk(4'h5, {25'h0, (e & 8'hBF) | 8'h40});
    apb(1'b1, spsc_pkg::DIR_OFF, 32'hFF);
    apb(1'b1, spsc_pkg::IRQ_MSK_OFF, 32'h1);
    mode <= spsc_pkg::SPSC_STOP;
    repeat (4) @(posedge clk);
    chk(4'hA, 33'h1);
    apb(1'b1, spsc_pkg::DATA_OFF, {24'h0, ~d});
    for (int k = 0; k < 3; k++) begin
      cm = 8'($urandom());
      cmp_out <= cm;
      repeat (3) @(posedge clk);
      chk(4'h2, {25'h0, (d & 8'hBF) | (cm & 8'h40)});
      chk(4'h1, 33'hFF);
    end
    chk(4'h4, 33'h0);
    chk(4'h5, 33'h0);
    apb(1'b1, spsc_pkg::IRQ_ST_OFF, 32'h1);
    @(posedge clk);
    chk(4'hA, 33'h0);
    mode <= spsc_pkg::SPSC_NORMAL;
    apb(1'b1, spsc_pkg::CTRL_OFF, 32'hF);
    apb(1'b1, spsc_pkg::PULL_OFF, 32'hFF);
    apb(1'b1, spsc_pkg::XINT_OFF, 32'h0F);
    apb(1'b1, spsc_pkg::IRQ_MSK_OFF, 32'h2);
    mode <= spsc_pkg::SPSC_WATCH;
    repeat (4) @(posedge clk);
    chk(4'h1, 33'h0);
    chk(4'h3, 33'h3F);
    chk(4'h5, 33'h0);
    chk(4'h6, {25'h0, e & 8'h0F});
    chk(4'h7, 33'h30);
    chk(4'h8, {25'h0, e & 8'hC0});
    rst_pin_in <= 1'b0;
    repeat (4) @(posedge clk);
    chk(4'h9, 33'h1);
    rst_pin_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk(4'h9, 33'h0);
    mode <= spsc_pkg::SPSC_NORMAL;
    repeat (3) @(posedge clk);
    chk(4'hA, 33'h1);
    apb(1'b1, spsc_pkg::OSC_OFF, 32'hFF);
    chk(4'h1, 33'hFC);
    chk(4'h4, 33'hFC);
    report_and_stop();
  end
endmodule : spsc_ctrl_tb
